// file: rtl/crf_regs.svh
// Constants of the CPU register file: offsets, flag bits, resets.
// Assumes an 8-bit APB byte address with one 32-bit word per register.
`ifndef CRF_REGS_SVH
`define CRF_REGS_SVH
`define CRF_OFF_BANK0    8'h00
`define CRF_OFF_BANK1    8'h20
`define CRF_OFF_PC       8'h40
`define CRF_OFF_VECTOR_TABLE_BASE     8'h44
`define CRF_OFF_USP      8'h48
`define CRF_OFF_ISP      8'h4C
`define CRF_OFF_SB       8'h50
`define CRF_OFF_FLG      8'h54
`define CRF_OFF_STAT     8'h58
`define CRF_FLG_C        0
`define CRF_FLG_D        1
`define CRF_FLG_Z        2
`define CRF_FLG_S        3
`define CRF_FLG_B        4
`define CRF_FLG_O        5
`define CRF_FLG_I        6
`define CRF_FLG_U        7
`define CRF_FLG_IPL_LO   12
`define CRF_FLG_IPL_HI   14
`define CRF_FLG_MASK     16'h70FF
`define CRF_FLG_RST      16'h0000
`define CRF_REG_RST      16'h0000
`define CRF_PC_RST       20'h00000
`define CRF_FIXVEC_BASE  20'hFFFDC
`define CRF_RST_VEC      20'hFFFFC
`define CRF_SW_U_LIMIT   6'h20
`define CRF_RST_HOLD_CYC 20
`define CRF_SEG_RST      24'hFFFFFF
`define CRF_COM_RST      4'hF
`define CRF_PULL_RST     2'h3
`define CRF_OE_RST       7'h00
`endif

// file: rtl/crf_pkg.sv
// Types of the CPU register file: selectors, sizes and carriers.
// Assumes the decoder, ALU and interrupt controller share these.
package crf_pkg;
    typedef enum logic [3:0] {
        SEL_R0 = 4'h0, SEL_R1 = 4'h1, SEL_R2 = 4'h2, SEL_R3 = 4'h3,
        SEL_A0 = 4'h4, SEL_A1 = 4'h5, SEL_FB = 4'h6, SEL_SB = 4'h7,
        SEL_USP = 4'h8, SEL_ISP = 4'h9, SEL_SP = 4'hA, SEL_PC = 4'hB,
        SEL_VECTOR_TABLE_BASE = 4'hC, SEL_FLG = 4'hD
    } crf_sel_t;
    typedef enum logic [1:0] {
        SZ_BYTE_L = 2'h0, SZ_BYTE_H = 2'h1, SZ_WORD = 2'h2, SZ_LONG = 2'h3
    } crf_size_t;
    typedef enum logic [1:0] {
        ACK_HW = 2'h0, ACK_SW = 2'h1, ACK_STEP = 2'h2
    } crf_ack_kind_t;
    typedef struct packed {
        logic        en;
        crf_sel_t    sel;
        crf_size_t   size;
        logic [31:0] data;
    } crf_wr_t;
    typedef struct packed {
        logic        valid;
        crf_size_t   size;
        logic [31:0] result;
        logic        carry;
        logic        ovf;
        logic [3:0]  upd;
    } crf_alu_t;
    typedef struct packed {
        logic          ack;
        crf_ack_kind_t kind;
        logic [5:0]    num;
        logic [2:0]    newIpl;
    } crf_ack_t;
    typedef struct packed {
        logic [23:0] seg;
        logic [3:0]  com;
        logic [1:0]  pull;
        logic [6:0]  oe;
    } crf_pins_t;
endpackage

// file: rtl/crf_core_regs.sv
// CPU register file: banked registers, PC, table base, stacks, flags.
// Assumes decoder, ALU and interrupt controller on sys_clk; APB
// debug writes are served only in cycles the core leaves idle; reads are served at any time.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "crf_regs.svh"
`default_nettype none

module crf_core_regs
    import crf_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire crf_wr_t     coreWr,
    input  wire crf_sel_t    rdSel,
    input  wire crf_size_t   rdSize,
    output logic [31:0]      rdData,
    input  wire crf_alu_t    alu,
    input  wire logic        pcInc,
    input  wire logic [2:0]  pcIncAmt,
    input  wire logic        instrDone,
    input  wire logic        irqReq,
    input  wire logic [2:0]  irqLevel,
    input  wire crf_ack_t    irqAck,
    output logic             irqAccept,
    output logic             stepIrq,
    input  wire logic        vecFixed,
    input  wire logic [5:0]  vecNum,
    output logic [19:0]      vecAddr,
    output logic             resetFetch,
    output logic [19:0]      pcOut,
    output logic [19:0]      intbOut,
    output logic [15:0]      flagWord,
    output logic [15:0]      curSp,
    output logic [15:0]      a0Out,
    output logic [15:0]      a1Out,
    output logic [15:0]      fbOut,
    output logic [15:0]      sbOut,
    input  wire crf_pins_t   pinsIn,
    output crf_pins_t        pinsOut
);
    localparam logic [7:0] OFF_B0 = `CRF_OFF_BANK0;
    localparam logic [7:0] OFF_B1 = `CRF_OFF_BANK1;

    // Upper partner of a 32-bit pair, 4'hF when the selector has none
    function automatic logic [3:0] hiOf(crf_sel_t s);
        logic [3:0] r;
        r = 4'hF;
        if (s == SEL_R0) r = 4'h2;
        if (s == SEL_R1) r = 4'h3;
        if (s == SEL_A0) r = 4'h5;
        return r;
    endfunction

    // Byte halves exist only on the first two data registers
    function automatic logic [15:0] mergeWord(logic [15:0] cur,
        logic [15:0] d, crf_size_t sz, logic byteOk);
        logic [15:0] r;
        r = d;
        if (byteOk && sz == SZ_BYTE_L) r = {cur[15:8], d[7:0]};
        if (byteOk && sz == SZ_BYTE_H) r = {d[7:0], cur[7:0]};
        return r;
    endfunction

    function automatic logic zeroOf(crf_size_t sz, logic [31:0] v);
        logic r;
        r = (v[15:0] == 16'h0000);
        if (sz == SZ_BYTE_L || sz == SZ_BYTE_H) r = (v[7:0] == 8'h00);
        if (sz == SZ_LONG) r = (v == 32'h0000_0000);
        return r;
    endfunction

    function automatic logic msbOf(crf_size_t sz, logic [31:0] v);
        logic r;
        r = v[15];
        if (sz == SZ_BYTE_L || sz == SZ_BYTE_H) r = v[7];
        if (sz == SZ_LONG) r = v[31];
        return r;
    endfunction

    // ALU flag update; upd bits are {O, S, Z, C}
    function automatic logic [15:0] applyAlu(logic [15:0] f,
        crf_alu_t a);
        logic [15:0] r;
        r = f;
        if (a.valid && a.upd[0]) r[`CRF_FLG_C] = a.carry;
        if (a.valid && a.upd[1]) r[`CRF_FLG_Z] = zeroOf(a.size, a.result);
        if (a.valid && a.upd[2]) r[`CRF_FLG_S] = msbOf(a.size, a.result);
        if (a.valid && a.upd[3]) r[`CRF_FLG_O] = a.ovf;
        return r;
    endfunction

    // Acknowledge effects; hardware ack also loads the new level
    function automatic logic [15:0] applyAck(logic [15:0] f,
        crf_ack_t k);
        logic [15:0] r;
        r = f;
        if (k.ack) begin
            r[`CRF_FLG_I] = 1'b0;
            if (k.kind == ACK_STEP) r[`CRF_FLG_D] = 1'b0;
            if (k.kind != ACK_SW || k.num < `CRF_SW_U_LIMIT)
                r[`CRF_FLG_U] = 1'b0;
            if (k.kind == ACK_HW)
                r[`CRF_FLG_IPL_HI:`CRF_FLG_IPL_LO] = k.newIpl;
        end
        return r;
    endfunction

    logic [15:0] bankReg [2][7];
    logic [19:0] pc_reg, vector_table_base_reg;
    logic [15:0] usp_reg, isp_reg, sb_reg, flg_reg;
    logic [19:0] pc_next, vector_table_base_next;
    logic [15:0] usp_next, isp_next, sb_next, flg_next;
    logic [15:0] flgBase;
    logic        start_reg, rdValid_reg;
    logic [31:0] rd_reg, prdata_reg, rd_next, apbRdVal;
    crf_pins_t   pins_reg;

    logic        bankSel, flgU, wrLong, coreBusy, apbWr;
    logic        apbB0, apbB1, apbMapped;
    logic [2:0]  apbSlot;
    logic [6:0]  coreEn, wrIsHi;
    logic [15:0] coreVal [7];
    logic [19:0] regView [16];
    logic [19:0] rdLo, rdHi;
    logic        wrUsp, wrIsp;
    logic [3:0]  statusBits;

    assign bankSel = flg_reg[`CRF_FLG_B];
    assign flgU    = flg_reg[`CRF_FLG_U];
    assign wrLong  = coreWr.size == SZ_LONG;

    // Banked write decode, pair upper halves included
    for (genvar i = 0; i < 7; i++) begin : g_bank
        assign wrIsHi[i]  = wrLong && hiOf(coreWr.sel) == 4'(i);
        assign coreEn[i]  = coreWr.en &&
            (coreWr.sel == crf_sel_t'(i) || wrIsHi[i]);
        assign coreVal[i] = wrIsHi[i] ? coreWr.data[31:16] :
            mergeWord(bankReg[bankSel][i], coreWr.data[15:0],
                      coreWr.size, i < 2);
        assign regView[i] = {4'h0, bankReg[bankSel][i]};
    end

    // Shared registers are seen the same from either bank
    assign regView[7]  = {4'h0, sb_reg};
    assign regView[8]  = {4'h0, usp_reg};
    assign regView[9]  = {4'h0, isp_reg};
    assign regView[10] = {4'h0, curSp};
    assign regView[11] = pc_reg;
    assign regView[12] = vector_table_base_reg;
    assign regView[13] = {4'h0, flg_reg};
    assign regView[14] = 20'h00000;
    assign regView[15] = 20'h00000;

    // Core read port, registered one cycle after the select
    assign rdLo    = regView[rdSel];
    assign rdHi    = regView[hiOf(rdSel)];
    assign rd_next = (rdSize == SZ_BYTE_L) ? {24'h0, rdLo[7:0]} :
                     (rdSize == SZ_BYTE_H) ? {24'h0, rdLo[15:8]} :
                     (rdSize == SZ_LONG) ? {rdHi[15:0], rdLo[15:0]} :
                     {12'h0, rdLo};

    // APB decode; writes wait while the core is writing anything
    assign coreBusy = coreWr.en | alu.valid | irqAck.ack | pcInc;
    assign pready   = pwrite ? ~coreBusy : rdValid_reg;
    assign apbWr    = psel & penable & pwrite & pready;
    assign apbSlot  = paddr[4:2];
    assign apbB0    = paddr[7:5] == OFF_B0[7:5] && apbSlot != 3'h7;
    assign apbB1    = paddr[7:5] == OFF_B1[7:5] && apbSlot != 3'h7;
    assign apbMapped = apbB0 | apbB1 | paddr == `CRF_OFF_PC |
        paddr == `CRF_OFF_VECTOR_TABLE_BASE | paddr == `CRF_OFF_USP |
        paddr == `CRF_OFF_ISP | paddr == `CRF_OFF_SB |
        paddr == `CRF_OFF_FLG | paddr == `CRF_OFF_STAT;
    assign pslverr  = psel & penable & pready & ~apbMapped;
    assign statusBits = {stepIrq, irqAccept, bankSel, start_reg};
    assign apbRdVal =
        apbB0 ? {16'h0, bankReg[0][apbSlot]} :
        apbB1 ? {16'h0, bankReg[1][apbSlot]} :
        (paddr == `CRF_OFF_PC)   ? {12'h0, pc_reg} :
        (paddr == `CRF_OFF_VECTOR_TABLE_BASE) ? {12'h0, vector_table_base_reg} :
        (paddr == `CRF_OFF_USP)  ? {16'h0, usp_reg} :
        (paddr == `CRF_OFF_ISP)  ? {16'h0, isp_reg} :
        (paddr == `CRF_OFF_SB)   ? {16'h0, sb_reg} :
        (paddr == `CRF_OFF_FLG)  ? {16'h0, flg_reg} :
        (paddr == `CRF_OFF_STAT) ? {28'h0, statusBits} : 32'h0;
    assign prdata = prdata_reg;
    assign rdData = rd_reg;

    // Shared next values; the core has priority, APB runs when idle
    assign pc_next =
        (coreWr.en && coreWr.sel == SEL_PC) ? coreWr.data[19:0] :
        (apbWr && paddr == `CRF_OFF_PC) ? pwdata[19:0] :
        pcInc ? pc_reg + {17'h0, pcIncAmt} : pc_reg;
    assign vector_table_base_next =
        (coreWr.en && coreWr.sel == SEL_VECTOR_TABLE_BASE) ? coreWr.data[19:0] :
        (apbWr && paddr == `CRF_OFF_VECTOR_TABLE_BASE) ? pwdata[19:0] :
        vector_table_base_reg;
    assign wrUsp = coreWr.en && (coreWr.sel == SEL_USP ||
        (coreWr.sel == SEL_SP && flgU));
    assign wrIsp = coreWr.en && (coreWr.sel == SEL_ISP ||
        (coreWr.sel == SEL_SP && !flgU));
    assign usp_next = wrUsp ? coreWr.data[15:0] :
        (apbWr && paddr == `CRF_OFF_USP) ? pwdata[15:0] : usp_reg;
    assign isp_next = wrIsp ? coreWr.data[15:0] :
        (apbWr && paddr == `CRF_OFF_ISP) ? pwdata[15:0] : isp_reg;
    assign sb_next =
        (coreWr.en && coreWr.sel == SEL_SB) ? coreWr.data[15:0] :
        (apbWr && paddr == `CRF_OFF_SB) ? pwdata[15:0] : sb_reg;

    // Flag chain: writes, then ALU, then acknowledge; reserved masked
    assign flgBase =
        (coreWr.en && coreWr.sel == SEL_FLG) ? coreWr.data[15:0] :
        (apbWr && paddr == `CRF_OFF_FLG) ? pwdata[15:0] : flg_reg;
    assign flg_next = applyAck(applyAlu(flgBase, alu), irqAck) &
        `CRF_FLG_MASK;

    // Interrupt gating by enable flag and strict priority compare
    assign irqAccept = irqReq && flg_reg[`CRF_FLG_I] &&
        irqLevel > flg_reg[`CRF_FLG_IPL_HI:`CRF_FLG_IPL_LO];
    assign stepIrq = instrDone && flg_reg[`CRF_FLG_D];

    // Fixed vectors ignore the table base; reset vector first
    assign vecAddr = start_reg ? `CRF_RST_VEC :
        vecFixed ? `CRF_FIXVEC_BASE + {12'h0, vecNum, 2'b00} :
        vector_table_base_reg + {12'h0, vecNum, 2'b00};
    assign resetFetch = start_reg;

    assign pcOut    = pc_reg;
    assign intbOut  = vector_table_base_reg;
    assign flagWord = flg_reg;
    assign curSp    = flgU ? usp_reg : isp_reg;
    assign a0Out    = bankReg[bankSel][4];
    assign a1Out    = bankReg[bankSel][5];
    assign fbOut    = bankReg[bankSel][6];
    assign sbOut    = sb_reg;
    assign pinsOut  = pins_reg;

    // Banked storage; only the active bank sees core writes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int b = 0; b < 2; b++)
                for (int i = 0; i < 7; i++)
                    bankReg[b][i] <= `CRF_REG_RST;
        end else begin
            for (int i = 0; i < 7; i++) begin
                if (coreEn[i]) bankReg[bankSel][i] <= coreVal[i];
                if (apbWr && apbB0 && apbSlot == 3'(i))
                    bankReg[0][i] <= pwdata[15:0];
                if (apbWr && apbB1 && apbSlot == 3'(i))
                    bankReg[1][i] <= pwdata[15:0];
            end
        end
    end

    // Shared registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_reg   <= `CRF_PC_RST;
            vector_table_base_reg <= `CRF_PC_RST;
            usp_reg  <= `CRF_REG_RST;
            isp_reg  <= `CRF_REG_RST;
            sb_reg   <= `CRF_REG_RST;
            flg_reg  <= `CRF_FLG_RST;
        end else begin
            pc_reg   <= pc_next;
            vector_table_base_reg <= vector_table_base_next;
            usp_reg  <= usp_next;
            isp_reg  <= isp_next;
            sb_reg   <= sb_next;
            flg_reg  <= flg_next;
        end
    end

    // Read data captured in the setup cycle gives a zero-wait read
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_reg      <= 32'h0000_0000;
            prdata_reg  <= 32'h0000_0000;
            rdValid_reg <= 1'b0;
        end else begin
            rd_reg      <= rd_next;
            rdValid_reg <= psel & ~penable & ~pwrite;
            if (psel & ~penable) prdata_reg <= apbRdVal;
        end
    end

    // Reset holds pins safe and arms one reset-vector fetch; the hold
    // time is the driver's duty, the core cannot count a held reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_reg <= 1'b1;
            pins_reg  <= '{seg: `CRF_SEG_RST, com: `CRF_COM_RST,
                           pull: `CRF_PULL_RST, oe: `CRF_OE_RST};
        end else begin
            start_reg <= 1'b0;
            pins_reg  <= pinsIn;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_bank_isolate: assert property (
        coreWr.en && coreWr.sel == SEL_R0 && coreWr.size == SZ_WORD &&
        !bankSel |=> bankReg[0][0] == $past(coreWr.data[15:0]) &&
        $stable(bankReg[1][0]))
        else $error("bank zero write leaked or lost");
    a_byte_high: assert property (
        coreWr.en && coreWr.sel == SEL_R1 && coreWr.size == SZ_BYTE_H
        |=> a0Out == $past(a0Out) &&
        regView[1][7:0] == $past(regView[1][7:0]))
        else $error("high byte write disturbed low byte");
    a_long_data: assert property (
        coreWr.en && coreWr.sel == SEL_R0 && wrLong
        |=> regView[2][15:0] == $past(coreWr.data[31:16]))
        else $error("pair upper half not written");
    a_long_addr: assert property (
        coreWr.en && coreWr.sel == SEL_A0 && wrLong
        |=> a1Out == $past(coreWr.data[31:16]) &&
        a0Out == $past(coreWr.data[15:0]))
        else $error("address pair not written");
    a_zero_flag: assert property (
        alu.valid && alu.upd[1] && alu.size == SZ_WORD && !irqAck.ack
        |=> flg_reg[`CRF_FLG_Z] == ($past(alu.result[15:0]) == 16'h0))
        else $error("zero flag wrong");
    a_sign_carry: assert property (
        alu.valid && alu.upd == 4'hF && alu.size == SZ_LONG
        |=> flg_reg[`CRF_FLG_S] == $past(alu.result[31]) &&
        flg_reg[`CRF_FLG_Z] == ($past(alu.result) == 32'h0) &&
        flg_reg[`CRF_FLG_C] == $past(alu.carry) &&
        flg_reg[`CRF_FLG_O] == $past(alu.ovf))
        else $error("sign, carry or overflow flag wrong");
    a_step_clear: assert property (
        irqAck.ack && irqAck.kind == ACK_STEP
        |=> !flg_reg[`CRF_FLG_D] && !flg_reg[`CRF_FLG_I])
        else $error("step ack left debug or enable set");
    a_ack_stack: assert property (
        irqAck.ack && irqAck.kind == ACK_SW && irqAck.num < 6'h20
        |=> !flgU && curSp == isp_reg)
        else $error("software ack kept user stack");
    a_accept_prio: assert property (
        irqAccept |-> flg_reg[`CRF_FLG_I] &&
        irqLevel > flagWord[14:12])
        else $error("interrupt accepted at low priority");
    a_reserved_zero: assert property (
        (flagWord & ~`CRF_FLG_MASK) == 16'h0000)
        else $error("reserved flag bit set");
    a_reset_fetch: assert property (
        resetFetch |-> vecAddr == `CRF_RST_VEC ##1 !resetFetch)
        else $error("reset vector fetch not single");
    a_fixed_vector: assert property (
        !resetFetch && vecFixed |-> vecAddr ==
        `CRF_FIXVEC_BASE + {12'h0, vecNum, 2'b00})
        else $error("fixed vector used table base");
    a_shared_keep: assert property (
        $changed(bankSel) && $past(coreWr.en) &&
        $past(coreWr.sel) == SEL_FLG && !$past(pcInc)
        |-> $stable(pc_reg) && $stable(sb_reg) &&
        $stable(vector_table_base_reg) && $stable(usp_reg))
        else $error("shared register changed on bank switch");

    c_bank_one: cover property (bankSel && coreWr.en && wrLong);
    c_hw_ack: cover property (irqAccept ##1 irqAck.ack);
    c_apb_read: cover property (psel && penable && pready && !pwrite);
    c_apb_stall: cover property (psel && penable && pwrite && !pready);
endmodule

`default_nettype wire

// file: test/crf_irq_model.sv
// Interrupt controller stand-in facing the CPU register file.
// Assumes the same clock; holdOff stalls all answers while high.
`timescale 1ns/1ps
`default_nettype none
module crf_irq_model import crf_pkg::*; (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       holdOff,
    input  wire logic       irqAccept,
    input  wire logic       stepIrq,
    input  wire logic [2:0] irqLevel,
    output crf_ack_t        irqAck
);
    // One ack per request; the idle cycle after it lets accept drop
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqAck <= '0;
        end else if (irqAck.ack || holdOff) begin
            irqAck <= '0;
        end else if (irqAccept) begin
            irqAck <= '{1'b1, ACK_HW, 6'h00, irqLevel};
        end else if (stepIrq) begin
            irqAck <= '{1'b1, ACK_STEP, 6'h01, 3'h0};
        end
    end
endmodule
`default_nettype wire

// file: test/cpu_register_file_flags_tb.sv
// Self-checking bench of the CPU register file, xorshift data.
// Assumes the interrupt model and the rtl include path.
`timescale 1ns/1ps
`default_nettype none
`include "crf_regs.svh"
module cpu_register_file_flags_tb import crf_pkg::*;;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, rerr, holdOff;
    logic        pcInc, instrDone, irqReq, irqAccept, stepIrq;
    logic        vecFixed, resetFetch;
    logic [2:0]  pcIncAmt, irqLevel;
    logic [5:0]  vecNum;
    logic [7:0]  paddr;
    logic [15:0] flagWord, curSp, a0Out, a1Out, fbOut, sbOut;
    logic [19:0] vecAddr, pcOut, intbOut;
    logic [31:0] pwdata, prdata, rdData, rv, r, u, s, sb;
    logic [31:0] seed = 32'h00000023;
    logic [31:0] d [2][7];
    crf_wr_t     coreWr;
    crf_sel_t    rdSel;
    crf_size_t   rdSize;
    crf_alu_t    alu;
    crf_ack_t    irqAck, swAck, modelAck;
    crf_pins_t   pinsIn, pinsOut;
    int          err_total = 0;
    int          tests_run = 0;

    // Clock and the merge of bench and model acknowledges
    always #25 sys_clk = ~sys_clk;
    assign irqAck = swAck.ack ? swAck : modelAck;

    crf_core_regs dut_u (
        .sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
        .pready, .prdata, .pslverr, .coreWr, .rdSel, .rdSize, .rdData,
        .alu, .pcInc, .pcIncAmt, .instrDone, .irqReq, .irqLevel, .irqAck,
        .irqAccept, .stepIrq, .vecFixed, .vecNum, .vecAddr, .resetFetch,
        .pcOut, .intbOut, .flagWord, .curSp, .a0Out, .a1Out, .fbOut,
        .sbOut, .pinsIn, .pinsOut
    );
    crf_irq_model model_u (
        .sys_clk, .rst_n, .holdOff, .irqAccept, .stepIrq, .irqLevel,
        .irqAck(modelAck)
    );

    // Helpers: random source, flag expectation, checks and transfers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Long results take sign and zero from all 32 bits
    function automatic logic [15:0] aluFlags(logic [31:0] v, logic lng,
                                             logic c, logic o);
        logic n, z;
        n = lng ? v[31] : v[15];
        z = lng ? (v == 32'h0000_0000) : (v[15:0] == 16'h0000);
        return {10'h000, o, 1'b0, n, z, 1'b0, c};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // APB master; no latency assumed, waits for pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] v);
        @(posedge sys_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= v;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rv = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cw(input crf_sel_t sl, input crf_size_t z,
                      input logic [31:0] v);
        @(posedge sys_clk);
        coreWr <= '{1'b1, sl, z, v};
        @(posedge sys_clk);
        coreWr.en <= 1'b0;
    endtask
    task automatic cr(input crf_sel_t sl, input logic [31:0] e);
        @(posedge sys_clk);
        rdSel <= sl;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk(rdData, e);
    endtask
    task automatic aluOp(input logic [31:0] v, input logic lng,
                         input logic c, input logic o);
        @(posedge sys_clk);
        alu <= '{1'b1, lng ? SZ_LONG : SZ_WORD, v, c, o, 4'hF};
        @(posedge sys_clk);
        alu.valid <= 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic swi(input logic [5:0] n);
        @(posedge sys_clk);
        swAck <= '{1'b1, ACK_SW, n, 3'h0};
        @(posedge sys_clk);
        swAck.ack <= 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Main sequence: reset, registers, flags, interrupts, vectors
    initial begin
        {psel, penable, pwrite, paddr, pwdata, holdOff} = '0;
        {pcInc, pcIncAmt, instrDone, irqReq, irqLevel, vecFixed} = '0;
        {vecNum, coreWr, alu, swAck} = '0;
        rdSel = SEL_R0;
        rdSize = SZ_WORD;
        pinsIn = crf_pins_t'({rnd(), 5'h15});
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(pinsOut.seg, 24'hFFFFFF);
        chk({pinsOut.com, pinsOut.pull, pinsOut.oe}, 13'h1F80);
        chk(vecAddr, 20'hFFFFC);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk(resetFetch, 1'b0);
        chk(pinsOut.oe, pinsIn.oe);
        apb(1'b1, `CRF_OFF_FLG, 32'hFFFFFFFF);
        apb(1'b0, `CRF_OFF_FLG, 32'h00000000);
        chk(rv, 32'h000070FF);
        apb(1'b0, 8'h80, 32'h00000000);
        chk(rerr, 1'b1);
        cw(SEL_FLG, SZ_WORD, 32'h00000000);
        sb = rnd();
        cw(SEL_SB, SZ_WORD, sb);
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 7; i++) begin
                d[b][i] = rnd();
                cw(crf_sel_t'(i), SZ_WORD, d[b][i]);
            end
            cw(SEL_FLG, SZ_WORD, 32'h00000010);
        end
        @(negedge sys_clk);
        chk(a0Out, d[1][4][15:0]);
        chk(fbOut, d[1][6][15:0]);
        chk(sbOut, sb[15:0]);
        for (int i = 0; i < 14; i++) begin
            apb(1'b0, 8'((i / 7) * 32 + (i % 7) * 4), 32'h00000000);
            chk(rv, {16'h0000, d[i / 7][i % 7][15:0]});
        end
        cw(SEL_FLG, SZ_WORD, 32'h00000000);
        cw(SEL_R1, SZ_BYTE_L, 32'h0000005A);
        cr(SEL_R1, {16'h0000, d[0][1][15:8], 8'h5A});
        cw(SEL_R1, SZ_BYTE_H, 32'h000000C3);
        cr(SEL_R1, 32'h0000C35A);
        r = rnd();
        cw(SEL_R0, SZ_LONG, r);
        cr(SEL_R2, {16'h0000, r[31:16]});
        cw(SEL_A0, SZ_LONG, ~r);
        @(negedge sys_clk);
        chk({a1Out, a0Out}, ~r);
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            if (i < 2)
                r[15:0] = (i == 1) ? 16'h8000 : 16'h0000;
            aluOp(r, i == 3, r[16], r[17]);
            u = aluFlags(r, i == 3, r[16], r[17]);
            chk(flagWord, u);
        end
        u = rnd();
        s = rnd();
        cw(SEL_USP, SZ_WORD, u);
        cw(SEL_ISP, SZ_WORD, s);
        for (int n = 31; n < 33; n++) begin
            cw(SEL_FLG, SZ_WORD, 32'h00000080);
            @(negedge sys_clk);
            chk(curSp, u[15:0]);
            swi(6'(n));
            chk(flagWord, (n < 32) ? 16'h0000 : 16'h0080);
            chk(curSp, (n < 32) ? s[15:0] : u[15:0]);
        end
        cw(SEL_FLG, SZ_WORD, 32'h00003040);
        for (int l = 3; l < 5; l++) begin
            @(posedge sys_clk);
            irqReq   <= 1'b1;
            irqLevel <= 3'(l);
            @(negedge sys_clk);
            chk(irqAccept, l > 3);
        end
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(flagWord, 16'h4000);
        chk(irqAccept, 1'b0);
        @(posedge sys_clk);
        irqReq <= 1'b0;
        cw(SEL_FLG, SZ_WORD, 32'h00000002);
        @(posedge sys_clk);
        instrDone <= 1'b1;
        @(negedge sys_clk);
        chk(stepIrq, 1'b1);
        @(posedge sys_clk);
        instrDone <= 1'b0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(flagWord, 16'h0000);
        r = rnd();
        apb(1'b1, `CRF_OFF_VECTOR_TABLE_BASE, r);
        apb(1'b1, `CRF_OFF_PC, ~r);
        @(posedge sys_clk);
        vecNum   <= 6'h05;
        pcInc    <= 1'b1;
        pcIncAmt <= 3'h3;
        @(posedge sys_clk);
        pcInc <= 1'b0;
        @(negedge sys_clk);
        chk(vecAddr, 20'(r[19:0] + 20'h00014));
        chk(pcOut, 20'(~r[19:0] + 20'h00003));
        chk(intbOut, r[19:0]);
        @(posedge sys_clk);
        vecFixed <= 1'b1;
        @(negedge sys_clk);
        chk(vecAddr, 20'hFFFF0);
        results();
    end

    // Cut a hang short; the sequence needs well under 1000 cycles
    initial begin
        #(50 * 4000);
        err_total++;
        results();
    end
endmodule
`default_nettype wire
